// ### core/ddcs_bank.sv
// Function
// - Over/undervoltage sets bit 22/21, outputs off
// - Supply back in range restores outputs automatically
// - Over-current sets flag, switches output off
// - Recovery enable restarts output after delay
// - No restart made with enable clear
// - Thermal shutdown sets bit 20, outputs held off
// - Temperature warning bit 19, informational only
// - Standby-to-active sets not-ready bit 18 until settled
// - Open load flagged after 1 ms low current
// - Gating enable makes output follow pulse input
// - Outputs 9, 10 use second pulse, others first
// - Status bit 0 is NOR of bits 1-22, over-current flags and other faults
// - Status bit 23 always reads one
`timescale 1ns/1ps
module ddcs_bank #(
    parameter int OL_FILTER_CYC = ddcs_pkg::OL_FILTER_CYC,
    parameter int CP_SETTLE_CYC = ddcs_pkg::CP_SETTLE_CYC
) (
    input  wire logic                     clk,
    input  wire logic                     srst,
    input  wire logic                     spi_clk,
    input  wire logic                     spi_csn_n,
    input  wire logic                     spi_sdi,
    output logic                          spi_sdo,
    output logic                          spi_sdo_oe,
    input  wire ddcs_pkg::ddcs_sense_type sense,
    input  wire logic                     first_pulse_gate_input,
    input  wire logic                     second_pulse_gate_input,
    input  wire logic [16:0]              stage_request,
    input  wire logic                     duty_select,
    input  wire logic                     status_reset,
    input  wire logic                     other_fault_any,
    output logic [16:0]                   stage_drive,
    output logic [10:0]                   oc_flag
);
    import ddcs_pkg::*;

    localparam logic [LONG_W-1:0]  OL_LIM  = LONG_W'(OL_FILTER_CYC - 1);
    localparam logic [LONG_W-1:0]  CP_LIM  = LONG_W'(CP_SETTLE_CYC - 1);
    localparam logic [RETRY_W-1:0] RT_LONG = RETRY_W'(RETRY_LONG - 1);
    localparam logic [RETRY_W-1:0] RT_SHRT = RETRY_W'(RETRY_SHRT - 1);

    // Output number served by a driver stage
    function automatic int stage_out(input int s);
        return (s < 12) ? (s / 2) : (s - 6);
    endfunction

    // Output is gated by the second pulse input
    function automatic logic uses_second(input int o);
        return (o == SECOND_A) || (o == SECOND_B);
    endfunction

    // Link side
    logic [4:0]        bit_cnt;   // Bits taken in this frame
    logic [22:0]       rx_shift;  // Incoming bits
    logic [WORD_W-1:0] rx_word;   // Last whole frame
    logic              rx_toggle; // Flips once per whole frame
    logic [WORD_W-1:0] tx_hold;   // Status snapshot, frozen in frame

    // Core side
    logic              csn_s1, csn_s2;
    logic [2:0]        tog_s;
    logic              new_word;
    logic [WORD_W-1:0] ctrl;      // Recovery and gating control
    ddcs_sense_type    sense_s1, sense_s2;
    logic [1:0]        pulse_s1, pulse_s2;
    ddcs_phase_type    phase;
    logic [LONG_W-1:0] settle_cnt;
    logic              tsd_flag;
    logic [16:0]       ol_flag;
    logic [10:0]       oc_off;    // Output held off after over-current
    logic [16:0]       want;      // Request after pulse gating
    logic              allow;     // Global permission to drive
    logic              supply_bad;
    logic [WORD_W-1:0] status_word;

    // Frame bit counter, cleared whenever the chip select is idle
    always_ff @(posedge spi_clk or posedge spi_csn_n) begin
        if (spi_csn_n) begin
            bit_cnt <= 5'h00;
        end else if (bit_cnt == 5'h17) begin
            bit_cnt <= 5'h00;
        end else begin
            bit_cnt <= bit_cnt + 5'h01;
        end
    end

    // Shift in MSB first on the rising edge
    always_ff @(posedge spi_clk) begin
        rx_shift <= {rx_shift[21:0], spi_sdi};
    end

    // Only a full 24-bit frame is handed over; short frames are dropped
    always_ff @(posedge spi_clk or posedge srst) begin
        if (srst) begin
            rx_word   <= CTRL_RESET;
            rx_toggle <= 1'b0;
        end else if (!spi_csn_n && bit_cnt == 5'h17) begin
            rx_word   <= {rx_shift, spi_sdi};
            rx_toggle <= ~rx_toggle;
        end
    end

    // Data out on the falling edge; idle level is one, the first status bit
    always_ff @(negedge spi_clk or posedge spi_csn_n) begin
        if (spi_csn_n) begin
            spi_sdo <= 1'b1;
        end else begin
            spi_sdo <= tx_hold[5'(5'h17 - bit_cnt)];
        end
    end

    // Pin driven only while selected
    assign spi_sdo_oe = ~spi_csn_n;

    // Synchronisers for chip select, frame toggle, detectors and pulses
    always_ff @(posedge clk) begin
        csn_s1   <= spi_csn_n;
        csn_s2   <= csn_s1;
        tog_s    <= {tog_s[1:0], rx_toggle};
        sense_s1 <= sense;
        sense_s2 <= sense_s1;
        pulse_s1 <= {second_pulse_gate_input, first_pulse_gate_input};
        pulse_s2 <= pulse_s1;
    end

    assign new_word = tog_s[1] ^ tog_s[2];

    // Snapshot only while idle, so the link reads a word that cannot move
    always_ff @(posedge clk) begin
        if (srst) begin
            tx_hold <= 24'h800000;
        end else if (csn_s2) begin
            tx_hold <= status_word;
        end
    end

    // Control word; a clear enable bit drops to standby with all bits zero
    always_ff @(posedge clk) begin
        if (srst) begin
            ctrl <= CTRL_RESET;
        end else if (new_word) begin
            ctrl <= rx_word[ENABLE_BIT] ? rx_word : CTRL_RESET;
        end
    end

    // Phase machine with charge-pump settling timer
    always_ff @(posedge clk) begin
        if (srst) begin
            phase      <= PH_STANDBY;
            settle_cnt <= '0;
        end else begin
            case (phase)
                PH_STANDBY: begin
                    settle_cnt <= '0;
                    if (ctrl[ENABLE_BIT]) begin
                        phase <= PH_SETTLE;
                    end
                end
                PH_SETTLE: begin
                    settle_cnt <= settle_cnt + 1'b1;
                    if (!ctrl[ENABLE_BIT]) begin
                        phase <= PH_STANDBY;
                    end else if (settle_cnt == CP_LIM) begin
                        phase <= PH_ACTIVE;
                    end
                end
                PH_ACTIVE: begin
                    if (!ctrl[ENABLE_BIT]) begin
                        phase <= PH_STANDBY;
                    end
                end
                default: begin
                    phase <= PH_STANDBY;
                end
            endcase
        end
    end

    // Thermal flag: detector set beats the reset-bit clear
    always_ff @(posedge clk) begin
        if (srst || phase == PH_STANDBY) begin
            tsd_flag <= 1'b0;
        end else if (sense_s2.thermal_shutdown_flag) begin
            tsd_flag <= 1'b1;
        end else if (status_reset) begin
            tsd_flag <= 1'b0;
        end
    end

    // Supply faults act live, so recovery needs no command
    assign supply_bad = sense_s2.ov | sense_s2.uv;
    assign allow = (phase == PH_ACTIVE) & ~supply_bad & ~tsd_flag;

    // Over-current handling, one per output
    genvar go;
    generate
        for (go = 0; go < OUT_N; go++) begin : g_out
            logic [RETRY_W-1:0] retry_cnt;
            logic [RETRY_W-1:0] retry_lim;
            // Off and on share of the pulsed current picked by the duty bit
            assign retry_lim = duty_select ? RT_SHRT : RT_LONG;

            // Sticky flag, set wins over the reset-bit clear
            always_ff @(posedge clk) begin
                if (srst || phase == PH_STANDBY) begin
                    oc_flag[go] <= 1'b0;
                end else if (sense_s2.oc[go]) begin
                    oc_flag[go] <= 1'b1;
                end else if (status_reset) begin
                    oc_flag[go] <= 1'b0;
                end
            end

            // Hold off; a recovery timer restarts only when enabled.
            // Enable is sampled at expiry, so no stray restart is made.
            always_ff @(posedge clk) begin
                if (srst || phase == PH_STANDBY) begin
                    oc_off[go]    <= 1'b0;
                    retry_cnt     <= '0;
                end else if (sense_s2.oc[go]) begin
                    oc_off[go]    <= 1'b1;
                    retry_cnt     <= '0;
                end else if (oc_off[go]) begin
                    retry_cnt <= retry_cnt + 1'b1;
                    if (retry_cnt == retry_lim && ctrl[RECOV_LSB + go]) begin
                        oc_off[go] <= 1'b0;
                        retry_cnt  <= '0;
                    end else if (status_reset) begin
                        oc_off[go] <= 1'b0;
                    end else if (retry_cnt == retry_lim) begin
                        retry_cnt  <= '0;
                    end
                end
            end
        end
    endgenerate

    // Stage drive and open-load filter, one per stage
    genvar gs;
    generate
        for (gs = 0; gs < STAGE_N; gs++) begin : g_stage
            localparam int O = stage_out(gs);
            logic [LONG_W-1:0] ol_cnt;
            logic              pulse_lvl;
            assign pulse_lvl = uses_second(O) ? pulse_s2[1] : pulse_s2[0];
            // Gated stages follow the selected pulse level
            assign want[gs] = stage_request[gs] & (~ctrl[GATE_LSB + O] | pulse_lvl);

            // Registered drive; the warning never enters this term
            always_ff @(posedge clk) begin
                if (srst) begin
                    stage_drive[gs] <= 1'b0;
                end else begin
                    stage_drive[gs] <= want[gs] & allow & ~oc_off[O];
                end
            end

            // Low current must last the whole filter time while driven
            always_ff @(posedge clk) begin
                if (srst || phase == PH_STANDBY) begin
                    ol_cnt       <= '0;
                    ol_flag[gs]  <= 1'b0;
                end else begin
                    if (stage_drive[gs] && sense_s2.low[gs]) begin
                        if (ol_cnt == OL_LIM) begin
                            ol_flag[gs] <= 1'b1;
                        end else begin
                            ol_cnt <= ol_cnt + 1'b1;
                        end
                    end else begin
                        ol_cnt <= '0;
                        if (status_reset) begin
                            ol_flag[gs] <= 1'b0;
                        end
                    end
                end
            end
        end
    endgenerate

    // Status word assembly
    always_comb begin
        status_word               = '0;
        status_word[ST_ALWAYS]    = 1'b1;
        status_word[ST_OV]        = sense_s2.ov;
        status_word[ST_UV]        = sense_s2.uv;
        status_word[ST_TSD]       = tsd_flag;
        status_word[ST_TWARN]     = sense_s2.twarn;
        status_word[ST_NRDY]      = (phase == PH_SETTLE);
        status_word[17:ST_OL_LSB] = ol_flag;
        status_word[ST_NOERR]     = ~(|status_word[22:1] | |oc_flag | other_fault_any);
    end

    // Checks
    supply_off_a: assert property (@(posedge clk) disable iff (srst)
        supply_bad |=> stage_drive == 17'h00000)
        else $error("supply fault left a stage on");
    auto_back_a: assert property (@(posedge clk) disable iff (srst)
        supply_bad ##1 (!supply_bad && phase == PH_ACTIVE && !tsd_flag && (want[0] && !oc_off[0]))
        |=> stage_drive[0])
        else $error("stage not restored after supply recovery");
    // Watches output 4 (stages 6 and 7); drive follows the hold-off one cycle late
    oc_cut_a: assert property (@(posedge clk) disable iff (srst)
        sense_s2.oc[3] && phase != PH_STANDBY |=> oc_flag[3] ##1 stage_drive[7:6] == 2'h0)
        else $error("over-current did not flag and cut output");
    retry_on_a: assert property (@(posedge clk) disable iff (srst)
        oc_off[3] && g_out[3].retry_cnt == g_out[3].retry_lim && ctrl[RECOV_LSB + 3]
        && !sense_s2.oc[3] && phase != PH_STANDBY |=> !oc_off[3])
        else $error("enabled recovery did not restart output");
    tsd_hold_a: assert property (@(posedge clk) disable iff (srst)
        tsd_flag && !status_reset && phase != PH_STANDBY |=> tsd_flag ##0 stage_drive == 17'h00000)
        else $error("thermal shutdown not held");
    settle_off_a: assert property (@(posedge clk) disable iff (srst)
        $rose(ctrl[ENABLE_BIT]) |=> phase == PH_SETTLE ##1 stage_drive == 17'h00000)
        else $error("outputs active while not ready");
    ol_set_a: assert property (@(posedge clk) disable iff (srst)
        phase != PH_STANDBY && stage_drive[5] && sense_s2.low[5] && g_stage[5].ol_cnt == OL_LIM
        |=> ol_flag[5])
        else $error("open load not flagged after filter");

    gate_two_a: assert property (@(posedge clk) disable iff (srst)
        ctrl[GATE_LSB + SECOND_B] && !pulse_s2[1] |=> !stage_drive[15])
        else $error("second pulse gate ignored");

    no_error_a: assert property (@(posedge clk) disable iff (srst)
        status_word[ST_NOERR] == !(sense_s2.ov || sense_s2.uv || tsd_flag || sense_s2.twarn
        || phase == PH_SETTLE || |ol_flag || |oc_flag || other_fault_any))
        else $error("no-error bit wrong");

    always_one_a: assert property (@(posedge clk) disable iff (srst)
        ##1 tx_hold[ST_ALWAYS])
        else $error("top status bit not one");

endmodule

// ### core/ddcs_pkg.sv
package ddcs_pkg;
    // Frame and channel sizes
    localparam int WORD_W  = 24;
    localparam int OUT_N   = 11;
    localparam int STAGE_N = 17;
    // Control word field positions
    localparam int ENABLE_BIT = 23;
    localparam int RECOV_LSB  = 12;
    localparam int GATE_LSB   = 1;
    // Outputs (zero based) that follow the second pulse input
    localparam int SECOND_A = 8;
    localparam int SECOND_B = 9;
    // Status word field positions
    localparam int ST_ALWAYS = 23;
    localparam int ST_OV     = 22;
    localparam int ST_UV     = 21;
    localparam int ST_TSD    = 20;
    localparam int ST_TWARN  = 19;
    localparam int ST_NRDY   = 18;
    localparam int ST_OL_LSB = 1;
    localparam int ST_NOERR  = 0;
    localparam logic [WORD_W-1:0] CTRL_RESET = 24'h000000;
    // Timing, internal clock at 250 MHz
    localparam int CLK_MHZ       = 250;
    localparam int OL_FILTER_US  = 1000;
    localparam int OL_FILTER_CYC = OL_FILTER_US * CLK_MHZ;
    localparam int CP_SETTLE_US  = 100;
    localparam int CP_SETTLE_CYC = CP_SETTLE_US * CLK_MHZ;
    localparam int RETRY_LONG_US = 8;
    localparam int RETRY_SHRT_US = 2;
    localparam int RETRY_LONG    = RETRY_LONG_US * CLK_MHZ;
    localparam int RETRY_SHRT    = RETRY_SHRT_US * CLK_MHZ;
    localparam int LONG_W        = 18;
    localparam int RETRY_W       = 12;
    // Analog detector levels, all from pins
    typedef struct packed {
        logic                ov;
        logic                uv;
        logic                thermal_shutdown_flag;
        logic                twarn;
        logic [OUT_N-1:0]    oc;
        logic [STAGE_N-1:0]  low;
    } ddcs_sense_type;
    // Operating phase, Gray along standby, settle, active
    typedef enum logic [1:0] {
        PH_STANDBY = 2'b00,
        PH_SETTLE  = 2'b01,
        PH_ACTIVE  = 2'b11
    } ddcs_phase_type;
endpackage

// ### verif/ddcs_spi_host.sv
`timescale 1ns/1ps
// Controller model: SPI master, mode 0, MSB first, 32 ns link period
module ddcs_spi_host (
    output logic      spi_clk,
    output logic      spi_csn_n,
    output logic      spi_sdi,
    input  wire logic spi_miso
);
    // Link clock stands low and the select is high between frames
    // A clean rising select edge clears the link bit counter and sets data out high
    initial begin
        spi_clk   = 1'b0;
        spi_csn_n = 1'b0;
        spi_sdi   = 1'b1;
        #1 spi_csn_n = 1'b1;
    end

    // One whole 24 bit frame; status is sampled on each rising edge
    task automatic frame(input logic [23:0] tx, output logic [23:0] rx);
        #3;
        spi_csn_n = 1'b0;
        // Select leads the first edge so the status snapshot can freeze
        #20;
        for (int k = 0; k < 24; k++) begin
            spi_sdi = tx[23-k];
            #16;
            spi_clk = 1'b1;
            rx[23-k] = spi_miso;
            #16;
            spi_clk = 1'b0;
        end
        #16;
        spi_csn_n = 1'b1;
        // Released data line must not keep looking valid
        spi_sdi = ~spi_sdi;
        #20;
    endtask
endmodule

// ### verif/tb_top.sv
`timescale 1ns/1ps
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin errors++; \
    $display("unexpected at %0t: got %h expected %h", $time, got, exp); end end
module tb_top;
    import ddcs_pkg::*;
    localparam int          LIMIT = 20000;      // Cycle ceiling, tests need about 4700
    localparam logic [23:0] EN    = 24'h800000; // Active mode, nothing else set
    localparam logic [16:0] ALL   = 17'h1FFFF;  // Every stage driven
    logic           clk = 1'b0;
    logic           srst = 1'b0;
    logic           spi_clk, spi_csn_n, spi_sdi, spi_sdo, spi_sdo_oe;
    wire            miso;
    ddcs_sense_type sense = '0;
    logic           pulse_a = 1'b0, pulse_b = 1'b0;
    logic [16:0]    stage_request = 17'h00000;
    logic           duty_select = 1'b0, status_reset = 1'b0, other_fault_any = 1'b0;
    logic [16:0]    stage_drive;
    logic [10:0]    oc_flag;
    logic [23:0]    st;                         // Last status word read
    int             errors = 0, total_checks = 0, cycles = 0;

    // Data out wire floats when the device is not selected
    assign miso = spi_sdo_oe ? spi_sdo : 1'bz;

    always #2 clk = ~clk;

    ddcs_spi_host host (.spi_clk(spi_clk), .spi_csn_n(spi_csn_n), .spi_sdi(spi_sdi), .spi_miso(miso));

    // Short filter and settle counts keep the run brief
    ddcs_bank #(.OL_FILTER_CYC(20), .CP_SETTLE_CYC(400)) DUT (
        .clk(clk), .srst(srst), .spi_clk(spi_clk), .spi_csn_n(spi_csn_n), .spi_sdi(spi_sdi),
        .spi_sdo(spi_sdo), .spi_sdo_oe(spi_sdo_oe), .sense(sense),
        .first_pulse_gate_input(pulse_a), .second_pulse_gate_input(pulse_b),
        .stage_request(stage_request), .duty_select(duty_select), .status_reset(status_reset),
        .other_fault_any(other_fault_any), .stage_drive(stage_drive), .oc_flag(oc_flag));

    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask

    // Frame out, then let the new control word land in the core
    task automatic xfer(input logic [23:0] w);
        host.frame(w, st);
        cyc(6);
    endtask

    // One cycle pulse of the reset bit of the other control word
    task automatic clear_flags;
        status_reset = 1'b1;
        cyc(1);
        status_reset = 1'b0;
        cyc(4);
    endtask

    task automatic print_verdict;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // A hang counts as a mismatch
    always @(posedge clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            errors++;
            print_verdict();
        end
    end

    initial begin
        // A real rising reset edge clears the link-side frame toggle
        #1 srst = 1'b1;
        cyc(3);
        srst = 1'b0;
        cyc(3);
        stage_request = ALL;
        // Start-up: snapshot taken before enabling, then settling phase
        xfer(EN);
        `CHK(st, 24'h800001)
        xfer(EN);
        `CHK(st, 24'hC40000 & 24'h840000)
        `CHK(stage_drive, 17'h00000)
        cyc(400);
        xfer(EN);
        `CHK(st, 24'h800001)
        `CHK(stage_drive, ALL)
        $display("test startup done");
        // Over- then undervoltage, outputs off and back by themselves
        for (int i = 0; i < 2; i++) begin
            sense.ov = (i == 0);
            sense.uv = (i == 1);
            cyc(6);
            `CHK(stage_drive, 17'h00000)
            xfer(EN);
            `CHK(st, EN | (24'h400000 >> i))
            sense.ov = 1'b0;
            sense.uv = 1'b0;
            cyc(6);
            `CHK(stage_drive, ALL)
        end
        $display("test supply done");
        // Warning changes nothing at the outputs
        sense.twarn = 1'b1;
        xfer(EN);
        `CHK(stage_drive, ALL)
        `CHK(st, 24'h880000)
        sense.twarn = 1'b0;
        // Thermal shutdown holds outputs off after the detector drops
        sense.thermal_shutdown_flag = 1'b1;
        cyc(6);
        sense.thermal_shutdown_flag = 1'b0;
        xfer(EN);
        `CHK(stage_drive, 17'h00000)
        `CHK(st, 24'h900000)
        clear_flags();
        `CHK(stage_drive, ALL)
        $display("test thermal done");
        // Over-current on output 4 without restart: waits for the reset bit
        sense.oc[3] = 1'b1;
        cyc(6);
        sense.oc[3] = 1'b0;
        `CHK(oc_flag, 11'h008)
        `CHK(stage_drive, 17'h1FF3F)
        cyc(600);
        `CHK(stage_drive, 17'h1FF3F)
        xfer(EN);
        `CHK(st, 24'h800000)
        clear_flags();
        `CHK(stage_drive, ALL)
        // Same fault with restart enabled and the short delay
        duty_select = 1'b1;
        xfer(24'h808000);
        sense.oc[3] = 1'b1;
        cyc(6);
        sense.oc[3] = 1'b0;
        cyc(450);
        `CHK(stage_drive, 17'h1FF3F)
        cyc(100);
        `CHK(stage_drive, ALL)
        `CHK(oc_flag, 11'h008)
        clear_flags();
        $display("test overcurrent done");
        // Gating of outputs 9 to 11: 9 and 10 on the second input, 11 on the first
        xfer(24'h800E00);
        for (int p = 0; p < 4; p++) begin
            pulse_a = p[0];
            pulse_b = p[1];
            cyc(6);
            `CHK(stage_drive, {p[0], p[1], p[1], 14'h3FFF})
        end
        $display("test gating done");
        // Brief low current on stage 5 past the filter time
        xfer(EN);
        sense.low[5] = 1'b1;
        cyc(40);
        sense.low[5] = 1'b0;
        xfer(EN);
        `CHK(st, 24'h800040)
        clear_flags();
        xfer(EN);
        `CHK(st, 24'h800001)
        // Faults in the other status word also drop the no-error bit
        other_fault_any = 1'b1;
        xfer(EN);
        `CHK(st, 24'h800000)
        other_fault_any = 1'b0;
        $display("test status done");
        print_verdict();
    end
endmodule
